// ---- core/sfw_core.sv ----
// framing, word length and status block of the serial unit
// assumes an outside bit clock tick, shifters and data buffers;
// this block decides when words move and what the flags show
`timescale 1ns/100ps

//
// Operation
// - sync direction bit: 1 input, 0 output
// - polarity bit sets sync and select level
// - master auto select drives pin during transfer
// - pulse width: whole word or one bit
// - words per sync: 1,2,4,8,16,32
// - audio forces framing, direction, two words, mid-sample
// - audio fields writable only while module off
// - underrun source used only if underrun noncritical
// - non-PCM audio forces word-wide sync pulse
// - nonzero length code n gives n+1 bits
// - zero length code uses coarse mode
// - fine length ignored while audio enabled
// - fine length never changes queue depth
// - frame error sticks until software clears
// - busy reads one during any transfer
// - underrun flag, cleared by disable, live if noncritical
// - shifter empty when buffer and shifter empty
// - overflow set when word lands on full buffer
// - standard mode receive full/empty follow store, read
// - standard mode transmit full/empty follow write, load
// - enhanced flags follow counts zero and full
// - six-bit receive and transmit entry counts
// - upper count bits exist by queue depth
// - enhanced bit selects queue, else single entry
module sfw_core import sfw_pkg::*; (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // register bus
    input  wire sfw_ahb_req_t ahb_req,
    output sfw_ahb_rsp_t     ahb_rsp,
    // serial timing
    input  wire logic        bit_tick,
    output logic [5:0]       word_bits,
    output logic             sample_at_end,
    // sync / slave select pin
    input  wire logic        slave_select_pin_i,
    output logic             slave_select_pin_o,
    output logic             slave_select_pin_oe,
    // shifter handshakes
    output logic             tx_load,
    output logic             tx_from_underrun,
    output logic             underrun_pattern_sel,
    output logic             rx_store,
    // data buffer side
    output logic             buf_wr,
    output logic [31:0]      buf_wdata,
    output logic             buf_rd,
    input  wire logic [31:0] buf_rdata
);

    sfw_core_t  q;
    sfw_core_t  d;

    // ------------------------------------------------------------
    // effective configuration
    // ------------------------------------------------------------
    logic       on;
    logic       master;
    logic       aud;
    logic       fr;
    logic       dir_in;
    logic       pol;
    logic       pw_word;
    logic       turnc;
    logic       rovnc;
    logic [5:0] gwords;
    logic [5:0] depth;
    logic [15:0] lockm;

    assign on     = q.cc[`SFW_CC_ON];
    assign master = q.cc[`SFW_CC_MASTER];
    assign aud    = q.fc[`SFW_FC_AUD];
    assign pol    = q.fc[`SFW_FC_POL];
    assign turnc  = q.fc[`SFW_FC_TURNC];
    assign rovnc  = q.fc[`SFW_FC_ROVNC];

    // audio overrides framing, direction and group size
    assign fr     = q.fc[`SFW_FC_FRM] | aud;
    assign dir_in = aud ? ~master : q.fc[`SFW_FC_DIR];
    assign gwords = aud ? `SFW_AUD_WORDS :
                    (q.fc[`SFW_FC_CNT] <= `SFW_CNT_MAX) ?
                    6'(6'h01 << q.fc[`SFW_FC_CNT]) :
                    6'h01;

    // in audio mode only PCM honours the one-bit pulse width
    assign pw_word = q.fc[`SFW_FC_PW] |
                     (aud & (q.fc[`SFW_FC_FMT] != `SFW_FMT_PCM));

    // length from fine field unless zero or audio
    assign word_bits = sfw_word_bits(q.wlen, q.cc[`SFW_CC_MODE],
                                     aud);

    // depth keyed to coarse mode only
    assign depth = sfw_depth(q.cc[`SFW_CC_MODE]);

    // slave always samples mid-bit, audio too
    assign sample_at_end = master & ~aud & q.cc[`SFW_CC_SMP];

    // underrun pattern only meaningful when underrun is soft
    assign underrun_pattern_sel = q.fc[`SFW_FC_URDT] & turnc;

    // audio fields frozen while running
    assign lockm = on ? (`SFW_FC_LOCK | `SFW_FC_LOCKAUD) :
                        16'h0000;

    // ------------------------------------------------------------
    // pin level and bus decode
    // ------------------------------------------------------------
    logic        sel_act;
    logic        sync_rise;
    logic        acc;
    logic        wr_data;
    logic        rd_data;
    logic [31:0] wd;

    // same pin carries sync or select, level per polarity
    assign sel_act   = slave_select_pin_i ^ ~pol;
    assign sync_rise = bit_tick & sel_act & ~q.sync_prev;

    assign acc     = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
    assign wd      = ahb_req.hwdata;
    assign wr_data = q.a_val & q.a_wr & (q.a_ofs == `SFW_OFS_DATA);
    assign rd_data = acc & ~ahb_req.hwrite &
                     (ahb_req.haddr[7:0] == `SFW_OFS_DATA);

    // ------------------------------------------------------------
    // buffer occupancy and status words
    // ------------------------------------------------------------
    logic       tx_empty;
    logic       tx_full;
    logic       rx_empty;
    logic       rx_full;
    logic       rx_inc;
    logic       hard_stop;
    logic       act_o;
    logic       nxt_needed;
    logic       restart;
    logic [5:0] tx_cnt;
    logic [5:0] rx_cnt;
    logic [5:0] bit_idx;
    logic [5:0] word_idx;
    logic       last_bit;
    logic       last_word;
    logic [15:0] stat_lo;
    logic [15:0] stat_hi;

    sfw_occupancy u_tx_occ (
        .core_clk (core_clk),
        .rst      (rst),
        .clr      (~on),
        .enh      (q.cc[`SFW_CC_ENH]),
        .depth    (depth),
        .push     (wr_data),
        .pop      (d.tx_load),
        .count    (tx_cnt),
        .empty    (tx_empty),
        .full     (tx_full)
    );

    sfw_occupancy u_rx_occ (
        .core_clk (core_clk),
        .rst      (rst),
        .clr      (~on),
        .enh      (q.cc[`SFW_CC_ENH]),
        .depth    (depth),
        .push     (rx_inc),
        .pop      (rd_data),
        .count    (rx_cnt),
        .empty    (rx_empty),
        .full     (rx_full)
    );

    sfw_word_ctr u_pos (
        .core_clk  (core_clk),
        .rst       (rst),
        .restart   (restart),
        .tick      (bit_tick),
        .wbits     (word_bits),
        .gwords    (gwords),
        .bit_idx   (bit_idx),
        .word_idx  (word_idx),
        .last_bit  (last_bit),
        .last_word (last_word)
    );

    // status image; busy and shifter-empty are live
    assign stat_lo = {3'b000, q.ferr,
                      q.st != SFW_IDLE,
                      2'b00, q.tur,
                      tx_empty & ~q.shf_full,
                      q.rov, rx_empty, 1'b0, tx_empty, 1'b0,
                      tx_full, rx_full};
    assign stat_hi = {2'b00, rx_cnt, 2'b00, tx_cnt};

    // sync pulse: first bit, or the whole first word of a group
    assign act_o = (q.st == SFW_SHIFT) && (word_idx == 6'h00) &&
                   (pw_word || bit_idx == 6'h00);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.tx_load  = 1'b0;
        d.tx_pat   = 1'b0;
        d.rx_store = 1'b0;
        d.buf_wr   = 1'b0;
        d.buf_rd   = rd_data & ~rx_empty;
        restart    = 1'b0;
        rx_inc     = 1'b0;
        hard_stop  = 1'b0;
        nxt_needed = 1'b0;

        // address phase; read data registered for the data phase
        d.a_val = acc;
        d.a_wr  = ahb_req.hwrite;
        d.a_ofs = ahb_req.haddr[7:0];
        if (acc && !ahb_req.hwrite) begin
            case (ahb_req.haddr[7:0])
                `SFW_OFS_CORE:  d.rdata = {26'h0, q.cc};
                `SFW_OFS_FRAME: d.rdata = {16'h0, q.fc};
                `SFW_OFS_WLEN:  d.rdata = {27'h0, q.wlen};
                `SFW_OFS_STAT:  d.rdata = {16'h0, stat_lo};
                `SFW_OFS_COUNT: d.rdata = {16'h0, stat_hi};
                `SFW_OFS_DATA:  d.rdata = buf_rdata;
                default:        d.rdata = 32'h0;
            endcase
        end

        // write data phase; clears come first so sets win below
        if (q.a_val && q.a_wr) begin
            case (q.a_ofs)
                `SFW_OFS_CORE:  d.cc = wd[5:0];
                `SFW_OFS_FRAME: d.fc = (q.fc & lockm) |
                                       (wd[15:0] & ~lockm);
                `SFW_OFS_WLEN:  d.wlen = wd[4:0];
                `SFW_OFS_STAT: begin
                    if (wd[`SFW_ST_FERR])
                        d.ferr = 1'b0;
                    if (wd[`SFW_ST_ROV])
                        d.rov = 1'b0;
                end
                `SFW_OFS_DATA: begin
                    // a write to a full buffer is dropped
                    if (!tx_full) begin
                        d.buf_wr = 1'b1;
                        d.wdata  = wd;
                    end
                end
                default: ;
            endcase
        end

        // sample the pin level once per serial bit
        if (bit_tick)
            d.sync_prev = sel_act;

        // transfer engine
        unique case (q.st)
            SFW_IDLE: begin
                restart = 1'b1;
                if (master ? !tx_empty :
                    bit_tick && (fr ? (dir_in ? sel_act : !tx_empty)
                                    : sel_act)) begin
                    d.st       = SFW_SHIFT;
                    d.shf_full = 1'b1;
                    if (!tx_empty)
                        d.tx_load = 1'b1;
                    else begin
                        d.tur    = 1'b1;
                        d.tx_pat = 1'b1;
                        hard_stop = !turnc;
                    end
                end
            end
            SFW_SHIFT: begin
                // a sync edge may only precede a new group
                if (fr && dir_in && sync_rise &&
                    !(last_bit && last_word))
                    d.ferr = 1'b1;
                if (bit_tick && last_bit) begin
                    d.rx_store = 1'b1;
                    if (rx_full) begin
                        d.rov     = 1'b1;
                        hard_stop = !rovnc;
                    end else
                        rx_inc = 1'b1;
                    // does the partner expect another word now
                    nxt_needed = fr ? (!last_word || (dir_in && sync_rise))
                                    : (!master && sel_act);
                    if (!tx_empty && (master || nxt_needed)) begin
                        d.tx_load = 1'b1;
                        if (turnc)
                            d.tur = 1'b0;
                    end else if (nxt_needed) begin
                        d.tur     = 1'b1;
                        d.tx_pat  = 1'b1;
                        hard_stop = hard_stop | !turnc;
                    end else begin
                        d.st       = SFW_IDLE;
                        d.shf_full = 1'b0;
                    end
                end
            end
            SFW_HALT: ;
            default: d.st = SFW_IDLE;
        endcase

        // critical error stops all traffic until disable
        if (hard_stop)
            d.st = SFW_HALT;

        // pin drive: sync when framed, auto select otherwise
        d.pin_oe = on && (fr ? !dir_in
                             : master && q.fc[`SFW_FC_ASS]);
        d.pin_o  = (fr ? act_o : q.st != SFW_IDLE) ^ ~pol;

        // disable resets the engine and every status flag
        if (!on) begin
            d.st        = SFW_IDLE;
            d.ferr      = 1'b0;
            d.rov       = 1'b0;
            d.tur       = 1'b0;
            d.shf_full  = 1'b0;
            d.sync_prev = 1'b0;
            d.tx_load   = 1'b0;
            d.tx_pat    = 1'b0;
            d.rx_store  = 1'b0;
            hard_stop   = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            q      <= '0;
            q.cc   <= `SFW_CC_RST;
            q.fc   <= `SFW_FC_RST;
            q.wlen <= `SFW_WLEN_RST;
        end else
            q <= d;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // zero wait states, always OKAY
    assign ahb_rsp.hreadyout = 1'b1;
    assign ahb_rsp.hresp     = 1'b0;
    assign ahb_rsp.hrdata    = q.rdata;

    assign slave_select_pin_o  = q.pin_o;
    assign slave_select_pin_oe = q.pin_oe;
    assign tx_load             = q.tx_load;
    assign tx_from_underrun    = q.tx_pat;
    assign rx_store            = q.rx_store;
    assign buf_wr              = q.buf_wr;
    assign buf_wdata           = q.wdata;
    assign buf_rd              = q.buf_rd;

endmodule

// ---- core/sfw_regs.svh ----
// register map, field positions and fixed figures of the framing unit
// assumes 32-bit AHB-Lite access, one register per aligned word
`ifndef SFW_REGS_SVH
`define SFW_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define SFW_OFS_CORE    8'h00
`define SFW_OFS_FRAME   8'h04
`define SFW_OFS_WLEN    8'h08
`define SFW_OFS_STAT    8'h0C
`define SFW_OFS_COUNT   8'h10
`define SFW_OFS_DATA    8'h14

// ----------------------------------------------------------------
// core control fields
// ----------------------------------------------------------------
`define SFW_CC_ON       0
`define SFW_CC_MASTER   1
`define SFW_CC_ENH      2
`define SFW_CC_SMP      3
`define SFW_CC_MODE     5:4
`define SFW_CC_RST      6'h00

// ----------------------------------------------------------------
// frame control fields
// ----------------------------------------------------------------
`define SFW_FC_AUD      15
`define SFW_FC_ROVNC    13
`define SFW_FC_TURNC    12
`define SFW_FC_URDT     10
`define SFW_FC_FMT      9:8
`define SFW_FC_FRM      7
`define SFW_FC_DIR      6
`define SFW_FC_POL      5
`define SFW_FC_ASS      4
`define SFW_FC_PW       3
`define SFW_FC_CNT      2:0
`define SFW_FC_LOCK     16'h0B00
`define SFW_FC_LOCKAUD  16'h8000
`define SFW_FC_RST      16'h0000
`define SFW_FMT_PCM     2'b11
`define SFW_CNT_MAX     3'b101

// ----------------------------------------------------------------
// word length, status and depth figures
// ----------------------------------------------------------------
`define SFW_WLEN_RST    5'h00
`define SFW_ST_FERR     12
`define SFW_ST_ROV      6
`define SFW_BITS_W32    6'h20
`define SFW_BITS_W16    6'h10
`define SFW_BITS_W8     6'h08
`define SFW_DEPTH_W32   6'h08
`define SFW_DEPTH_W16   6'h10
`define SFW_DEPTH_W8    6'h20
`define SFW_AUD_WORDS   6'h02

`endif

// ---- core/sfw_pkg.sv ----
// types and shared decoders of the framing unit
// assumes sfw_regs.svh on the include path
`include "sfw_regs.svh"

package sfw_pkg;

    // ------------------------------------------------------------
    // bus carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } sfw_ahb_req_t;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } sfw_ahb_rsp_t;

    // ------------------------------------------------------------
    // engine state and register image
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SFW_IDLE  = 2'b00,
        SFW_SHIFT = 2'b01,
        SFW_HALT  = 2'b10
    } sfw_state_t;

    typedef struct packed {
        sfw_state_t  st;
        logic [5:0]  cc;
        logic [15:0] fc;
        logic [4:0]  wlen;
        logic        ferr;
        logic        rov;
        logic        tur;
        logic        shf_full;
        logic        sync_prev;
        logic        a_val;
        logic        a_wr;
        logic [7:0]  a_ofs;
        logic [31:0] rdata;
        logic        buf_wr;
        logic [31:0] wdata;
        logic        buf_rd;
        logic        tx_load;
        logic        tx_pat;
        logic        rx_store;
        logic        pin_o;
        logic        pin_oe;
    } sfw_core_t;

    // bits per serial word from fine and coarse length fields
    function automatic logic [5:0] sfw_word_bits(input logic [4:0] wlen,
                                                 input logic [1:0] mode,
                                                 input logic       audio);
        if (wlen != 5'h00 && !audio)
            return 6'({1'b0, wlen} + 6'h01);
        else if (mode[1])
            return `SFW_BITS_W32;
        else if (mode[0])
            return `SFW_BITS_W16;
        else
            return `SFW_BITS_W8;
    endfunction

    // queue depth follows the coarse mode only
    function automatic logic [5:0] sfw_depth(input logic [1:0] mode);
        if (mode[1])
            return `SFW_DEPTH_W32;
        else if (mode[0])
            return `SFW_DEPTH_W16;
        else
            return `SFW_DEPTH_W8;
    endfunction

endpackage

// ---- core/sfw_occupancy.sv ----
// occupancy counter and empty/full flags of one buffer direction
// assumes push and pop are one-cycle pulses in the core clock domain
`timescale 1ns/100ps

module sfw_occupancy import sfw_pkg::*; (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // configuration
    input  wire logic       clr,
    input  wire logic       enh,
    input  wire logic [5:0] depth,
    // events
    input  wire logic       push,
    input  wire logic       pop,
    // status
    output logic [5:0]      count,
    output logic            empty,
    output logic            full
);

    typedef struct packed {
        logic [5:0] cnt;
    } sfw_occ_t;

    sfw_occ_t   q;
    sfw_occ_t   d;
    logic [5:0] lim;
    logic       up;
    logic       dn;

    // standard mode is a single holding entry
    assign lim   = enh ? depth : 6'h01;
    assign empty = q.cnt == 6'h00;
    assign full  = q.cnt == lim;
    assign up    = push & ~full;
    assign dn    = pop & ~empty;

    // low count bits always exist
    assign count[2:0] = q.cnt[2:0];

    // upper bits only exist for deep enough queues
    for (genvar i = 3; i < 6; i++) begin : g_bit
        assign count[i] = q.cnt[i] & (depth >= (6'h01 << i));
    end

    // push fills, pop drains; together they cancel unless the count is empty or full
    always_comb begin
        d = q;
        if (clr)
            d.cnt = 6'h00;
        else if (up && !dn)
            d.cnt = q.cnt + 6'h01;
        else if (dn && !up)
            d.cnt = q.cnt - 6'h01;
    end

    always_ff @(posedge core_clk) begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

endmodule

// ---- core/sfw_word_ctr.sv ----
// bit and word position inside a sync group
// assumes tick is a one-cycle pulse per serial bit
`timescale 1ns/100ps

module sfw_word_ctr import sfw_pkg::*; (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // control
    input  wire logic       restart,
    input  wire logic       tick,
    input  wire logic [5:0] wbits,
    input  wire logic [5:0] gwords,
    // position
    output logic [5:0]      bit_idx,
    output logic [5:0]      word_idx,
    output logic            last_bit,
    output logic            last_word
);

    typedef struct packed {
        logic [5:0] bit_n;
        logic [5:0] word_n;
    } sfw_wc_t;

    sfw_wc_t q;
    sfw_wc_t d;

    assign bit_idx   = q.bit_n;
    assign word_idx  = q.word_n;
    assign last_bit  = q.bit_n == wbits - 6'h01;
    assign last_word = q.word_n == gwords - 6'h01;

    // word index wraps at the end of each group
    always_comb begin
        d = q;
        if (restart)
            d = '0;
        else if (tick) begin
            if (last_bit) begin
                d.bit_n  = 6'h00;
                d.word_n = last_word ? 6'h00 : q.word_n + 6'h01;
            end else
                d.bit_n = q.bit_n + 6'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

endmodule

// ---- test/sfw_core_monitor.sv ----
// port checker of the framing unit core
// assumes a bind onto sfw_core, one clock
`timescale 1ns/100ps
module sfw_core_monitor import sfw_pkg::*; (
    // clock and reset
    input wire logic         core_clk,
    input wire logic         rst,
    // watched ports
    input wire sfw_ahb_req_t ahb_req,
    input wire sfw_ahb_rsp_t ahb_rsp,
    input wire logic         bit_tick,
    input wire logic [5:0]   word_bits,
    input wire logic         tx_load,
    input wire logic         tx_from_underrun,
    input wire logic         rx_store,
    input wire logic         buf_wr,
    input wire logic [31:0]  buf_wdata,
    input wire logic         buf_rd,
    input wire logic         slave_select_pin_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // address phases as the slave takes them
    logic ap, wd, rd, rdd;
    assign ap = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
    assign rd = ap & !ahb_req.hwrite;
    assign wd = ap & ahb_req.hwrite & (ahb_req.haddr[7:0] == 8'h14);
    assign rdd = rd & (ahb_req.haddr[7:0] == 8'h14);
    property p_len; word_bits inside {[6'h02:6'h20]}; endproperty
    a_len: assert property (p_len)
        else $error("word length");
    property p_wr; buf_wr |-> $past(wd, 2); endproperty
    a_wr: assert property (p_wr)
        else $error("stray push");
    property p_wd; buf_wr |-> buf_wdata == $past(ahb_req.hwdata); endproperty
    a_wd: assert property (p_wd)
        else $error("push data");
    property p_rd; buf_rd |-> $past(rdd); endproperty
    a_rd: assert property (p_rd)
        else $error("stray pop");
    property p_rx; rx_store |-> $past(bit_tick); endproperty
    a_rx: assert property (p_rx)
        else $error("store off tick");
    property p_ex; !(tx_load && tx_from_underrun); endproperty
    a_ex: assert property (p_ex)
        else $error("double load");
    property p_hold; !$past(rd) |-> $stable(ahb_rsp.hrdata); endproperty
    a_hold: assert property (p_hold)
        else $error("read data moved");
    // reset itself is the cause here, so no disable
    property p_rst;
        disable iff (1'b0)
            rst |=> !tx_load && !rx_store && !slave_select_pin_oe;
    endproperty
    a_rst: assert property (p_rst)
        else $error("busy after reset");
    c_rx: cover property (rx_store);
    c_wr: cover property (buf_wr);
    c_rd: cover property (buf_rd);
endmodule

bind sfw_core sfw_core_monitor u_mon (
    .core_clk(core_clk), .rst(rst), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
    .bit_tick(bit_tick), .word_bits(word_bits), .tx_load(tx_load),
    .tx_from_underrun(tx_from_underrun), .rx_store(rx_store),
    .buf_wr(buf_wr), .buf_wdata(buf_wdata), .buf_rd(buf_rd),
    .slave_select_pin_oe(slave_select_pin_oe)
);

// ---- test/sfw_far_end.sv ----
// far end model: bit ticks and group sync
// assumes synchronous active high rst
`timescale 1ns/100ps
module sfw_far_end (
    // clock and control
    input wire logic core_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic drive,
    // link side
    output logic     bit_tick,
    output logic     sync_o,
    output logic     sync_oe
);
    logic [4:0] cnt_q;
    // four core cycles a bit, eight bits a group; still when idle
    always_ff @(posedge core_clk) begin
        if (rst || !run)
            cnt_q <= 5'h00;
        else
            cnt_q <= cnt_q + 5'h01;
    end
    assign bit_tick = run && cnt_q[1:0] == 2'h3;
    assign sync_o = cnt_q[4:2] == 3'h0;
    assign sync_oe = drive;
endmodule

// ---- test/tb.sv ----
// self-checking bench of the framing unit core
// assumes sfw_far_end makes the bit ticks
`timescale 1ns/100ps
module tb import sfw_pkg::*;;
    sfw_ahb_req_t q;
    sfw_ahb_rsp_t s;
    logic         core_clk = 1'b0;
    logic         rst = 1'b1;
    logic         run = 1'b0;
    logic         tick, so, soe, fo, foe, rxs, sae, ups;
    logic [5:0]   wb;
    logic [31:0]  r;
    int           error_cnt = 0;
    int           total_checks = 0;
    // rows: length code, coarse mode, bits per word
    logic [12:0]  rows [7] = '{13'h0102, 13'h1F20, 13'h0008, 13'h0050,
                               13'h00A0, 13'h00E0, 13'h1091};
    wire          pin = soe ? so : (foe ? fo : 1'b1); // pull-up when free
    always #5 core_clk = ~core_clk;
    sfw_core uut (.core_clk(core_clk), .rst(rst), .ahb_req(q), .ahb_rsp(s),
        .bit_tick(tick), .word_bits(wb), .sample_at_end(sae),
        .slave_select_pin_i(pin), .slave_select_pin_o(so),
        .slave_select_pin_oe(soe), .tx_load(), .tx_from_underrun(),
        .underrun_pattern_sel(ups), .rx_store(rxs), .buf_wr(), .buf_wdata(),
        .buf_rd(), .buf_rdata(32'h000000C3));
    sfw_far_end fe (.core_clk(core_clk), .rst(rst), .run(run),
        .drive(run), .bit_tick(tick), .sync_o(fo), .sync_oe(foe));
    task chk(input string n, input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    // one single transfer; entered just after a rising edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        q.hsel <= 1'b1;
        q.htrans <= 2'b10;
        q.hwrite <= w;
        q.haddr <= {24'h000000, a};
        do @(posedge core_clk); while (s.hreadyout !== 1'b1);
        q.hsel <= 1'b0;
        q.htrans <= 2'b00;
        q.hwdata <= d;
        do @(posedge core_clk); while (s.hreadyout !== 1'b1);
        r = s.hrdata;
    endtask
    task end_sim;
        if (error_cnt == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        end_sim;
    end
    initial begin
        q = '0;
        q.hready = 1'b1;
        q.hsize = 3'h2;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        bus(1'b1, 8'h20, 32'hFFFFFFFF);
        bus(1'b0, 8'h0C, 32'h0);
        chk("status", r, 32'h000000A8);
        foreach (rows[i]) begin
            bus(1'b1, 8'h00, {26'h0, rows[i][7:6], 4'h0});
            bus(1'b1, 8'h08, {27'h0, rows[i][12:8]});
            #1 chk("bits", {26'h0, wb}, {26'h0, rows[i][5:0]});
            @(posedge core_clk);
        end
        // audio hides the fine length, then locks while on
        bus(1'b1, 8'h04, 32'h00008000);
        #1 chk("audio", {26'h0, wb}, 32'h00000020);
        @(posedge core_clk);
        bus(1'b1, 8'h00, 32'h00000001);
        bus(1'b1, 8'h04, 32'h0000043D);
        bus(1'b0, 8'h04, 32'h0);
        chk("frame", r, 32'h0000843D);
        chk("urdt", {31'h0, ups}, 32'h0);
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b1, 8'h04, 32'h00000030);
        bus(1'b1, 8'h08, 32'h0);
        // one eight-bit master word through the queue, auto select on
        run <= 1'b1;
        bus(1'b1, 8'h00, 32'h0000000F);
        bus(1'b1, 8'h14, 32'h0000005A);
        chk("smp", {31'h0, sae}, 32'h1);
        @(posedge core_clk);
        bus(1'b0, 8'h0C, 32'h0);
        chk("status", r, 32'h00000828);
        chk("pin", {30'h0, soe, so}, 32'h3);
        for (int k = 0; k < 300 && rxs !== 1'b1; k++) @(posedge core_clk);
        chk("rx_store", {31'h0, rxs}, 32'h1);
        bus(1'b0, 8'h0C, 32'h0);
        chk("status", r, 32'h00000088);
        chk("pin", {30'h0, soe, so}, 32'h2);
        bus(1'b0, 8'h10, 32'h0);
        chk("counts", r, 32'h00000100);
        bus(1'b0, 8'h14, 32'h0);
        chk("data", r, 32'h000000C3);
        @(posedge core_clk);
        bus(1'b0, 8'h0C, 32'h0);
        chk("status", r, 32'h000000A8);
        // framed slave on the far end's sync, soft underrun
        bus(1'b1, 8'h04, 32'h000010E0);
        bus(1'b1, 8'h00, 32'h00000005);
        for (int k = 0; k < 300 && rxs !== 1'b1; k++) @(posedge core_clk);
        bus(1'b0, 8'h0C, 32'h0);
        chk("status", r, 32'h00000908);
        end_sim;
    end
endmodule
